// >>> common/i2ca_consts.svh
// Timing and width constants for the multi-controller bus engine.
// Assumes the link clock period below; counts round minimum times up.
`ifndef I2CA_CONSTS_SVH
`define I2CA_CONSTS_SVH

`define I2CA_REF_NS      25
`define I2CA_LINK_NS     80
`define I2CA_T_LOW_NS    4700
`define I2CA_T_HIGH_NS   4000
`define I2CA_T_HD_STA_NS 4000
`define I2CA_T_SU_STO_NS 4000
`define I2CA_CEIL(t)     (((t) + `I2CA_LINK_NS - 1) / `I2CA_LINK_NS)
`define I2CA_T_LOW_CYC   `I2CA_CEIL(`I2CA_T_LOW_NS)
`define I2CA_T_HIGH_CYC  `I2CA_CEIL(`I2CA_T_HIGH_NS)
`define I2CA_T_HD_CYC    `I2CA_CEIL(`I2CA_T_HD_STA_NS)
`define I2CA_T_SU_CYC    `I2CA_CEIL(`I2CA_T_SU_STO_NS)
`define I2CA_CNT_W       8
`define I2CA_BYTE_W      8
`define I2CA_ACK_IDX     4'h8
`define I2CA_SDA_HOLD    8'h01

`endif

// >>> common/i2ca_line_if.sv
// Filtered bus line levels passed from the sampler to the engine.
// Assumes both ends run on the link clock.
`timescale 1ns/100ps
interface i2ca_line_if;
	logic scl; // Filtered clock line level
	logic sda; // Filtered data line level

	modport sampler (output scl, output sda);
	modport consumer (input scl, input sda);
endinterface

// >>> common/i2ca_pkg.sv
// Types shared by the bus engine modules.
// Assumes nothing of its surroundings.
package i2ca_pkg;
	// Commands a user may issue
	typedef enum logic [1:0] {
		I2CA_CMD_START,
		I2CA_CMD_WRITE,
		I2CA_CMD_READ,
		I2CA_CMD_STOP
	} i2ca_cmd_t;

	// Link-side engine states
	typedef enum logic [2:0] {
		I2CA_ST_IDLE,
		I2CA_ST_START,
		I2CA_ST_LOW,
		I2CA_ST_RISE,
		I2CA_ST_HIGH,
		I2CA_ST_DONE
	} i2ca_state_t;
endpackage

// >>> logic/i2ca_line_filter.sv
// Samples both open-drain lines, two flops then a one-cycle agreement filter.
// Assumes link clock far faster than the bus bit rate.
`timescale 1ns/100ps
module i2ca_line_filter (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic ce_in,
	input  wire logic scl_in,
	input  wire logic sda_in,
	i2ca_line_if.sampler lines
);
	logic [1:0] meta_reg; // First stage, read only by the second
	logic [1:0] sync_reg; // Second stage
	logic [1:0] prev_reg; // Previous second-stage value
	logic [1:0] filt_reg; // Accepted levels

	// Idle bus reads high after reset
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			meta_reg <= 2'h3;
			sync_reg <= 2'h3;
			prev_reg <= 2'h3;
			filt_reg <= 2'h3;
		end else if (ce_in) begin
			meta_reg <= {scl_in, sda_in};
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
			// Single-sample spikes never reach the engine
			for (int i = 0; i < 2; i++) begin
				if (sync_reg[i] == prev_reg[i]) begin
					filt_reg[i] <= sync_reg[i];
				end
			end
		end
	end

	assign lines.scl = filt_reg[1];
	assign lines.sda = filt_reg[0];
endmodule

// >>> logic/i2ca_toggle_sync.sv
// Two-flop synchroniser with an edge pulse on the synced level.
// Assumes the input is a level or toggle from another domain.
`timescale 1ns/100ps
module i2ca_toggle_sync (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic ce_in,
	input  wire logic d_in,
	output logic      level_out,
	output logic      edge_out
);
	logic meta_reg; // First stage, read only by the second
	logic sync_reg; // Second stage
	logic last_reg; // Previous synced value

	// Synchroniser chain
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end else if (ce_in) begin
			meta_reg <= d_in;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign level_out = sync_reg;
	assign edge_out  = ce_in & (sync_reg ^ last_reg);
endmodule

// >>> logic/i2ca_top.sv
// Multi-controller bus engine: clock synchronisation, arbitration, stretching.
// Assumes pull-ups outside; user port on ref_clk_in, bus logic on link_clk_in.
`timescale 1ns/100ps
`include "i2ca_consts.svh"
module i2ca_top import i2ca_pkg::*; #(
	parameter bit                ARB_EN    = 1'b1,
	parameter int unsigned       CNT_W     = `I2CA_CNT_W,
	parameter logic [CNT_W-1:0]  T_LOW_CYC = CNT_W'(`I2CA_T_LOW_CYC),
	parameter logic [CNT_W-1:0]  T_HIGH_CYC = CNT_W'(`I2CA_T_HIGH_CYC),
	parameter logic [CNT_W-1:0]  T_HD_CYC  = CNT_W'(`I2CA_T_HD_CYC),
	parameter logic [CNT_W-1:0]  T_SU_CYC  = CNT_W'(`I2CA_T_SU_CYC)
) (
	input  wire logic       ref_clk_in,
	input  wire logic       srst_in,
	input  wire logic       ce_in,
	input  wire logic       cmd_valid_in,
	input  wire logic [1:0] cmd_kind_in,
	input  wire logic [7:0] cmd_data_in,
	input  wire logic       cmd_ack_in,
	output logic            cmd_ready_out,
	output logic            rsp_valid_out,
	output logic [7:0]      rsp_data_out,
	output logic            rsp_nack_out,
	output logic            arb_lost_out,
	input  wire logic       link_clk_in,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            scl_out,
	output logic            scl_oe_out,
	output logic            sda_out,
	output logic            sda_oe_out
);
	// Reference domain
	logic        ready_reg;     // Engine free for a command
	logic        req_tgl_reg;   // Command toggle to link side
	i2ca_cmd_t   kind_reg;      // Held command kind
	logic [7:0]  data_reg;      // Held write data
	logic        ack_reg;       // Held acknowledge choice for reads
	logic        rsp_valid_reg; // Answer pulse
	logic [7:0]  rsp_data_reg;  // Answer byte
	logic        rsp_nack_reg;  // Answer acknowledge level
	logic        lost_out_reg;  // Arbitration loss pulse
	logic        done_edge;     // Link finished, seen here

	// Link domain
	logic        rst_l;         // Reset seen on link clock
	logic        ce_l;          // Enable seen on link clock
	logic        req_edge;      // New command seen on link clock
	i2ca_state_t state_reg;     // Engine state
	logic [CNT_W-1:0] cnt_reg;  // Phase timer
	logic [3:0]  bit_reg;       // Bit index in byte, 8 is acknowledge
	logic [7:0]  shift_reg;     // Data shifter
	logic        smp_reg;       // Data seen at clock rise
	i2ca_cmd_t   kind_l_reg;    // Command copy on link side
	logic        ack_l_reg;     // Acknowledge copy on link side
	logic        scl_oe_reg;    // Pull clock low
	logic        sda_oe_reg;    // Pull data low
	logic        zero_reg;      // Constant low drive level
	logic        lost_reg;      // Arbitration lost this command
	logic        nack_reg;      // Acknowledge level seen
	logic        done_tgl_reg;  // Finish toggle to reference side
	logic [1:0]  tx;            // Own bit: {sending, level}

	i2ca_line_if lines ();

	// Timer reached its limit
	function automatic logic cnt_hit(input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] lim);
		cnt_hit = (c >= lim - CNT_W'(1));
	endfunction

	// Whether and what this end sends in the current bit cell
	function automatic logic [1:0] tx_bit(input i2ca_cmd_t k, input logic [3:0] b,
		input logic [7:0] s, input logic a);
		tx_bit = 2'h0;
		case (k)
			I2CA_CMD_WRITE: tx_bit = (b == `I2CA_ACK_IDX) ? 2'h1 : {1'b1, s[7]};
			I2CA_CMD_READ:  tx_bit = (b == `I2CA_ACK_IDX) ? {1'b1, ~a} : 2'h1;
			I2CA_CMD_STOP:  tx_bit = 2'h2;
			default:        tx_bit = 2'h1;
		endcase
	endfunction

	// Link-side reset and enable levels
	i2ca_toggle_sync u_rst_sync (
		.clk_in    (link_clk_in),
		.rst_in    (1'b0),
		.ce_in     (1'b1),
		.d_in      (srst_in),
		.level_out (rst_l),
		.edge_out  ()
	);
	i2ca_toggle_sync u_ce_sync (
		.clk_in    (link_clk_in),
		.rst_in    (1'b0),
		.ce_in     (1'b1),
		.d_in      (ce_in),
		.level_out (ce_l),
		.edge_out  ()
	);

	// Command toggle into the link domain
	i2ca_toggle_sync u_req_sync (
		.clk_in    (link_clk_in),
		.rst_in    (rst_l),
		.ce_in     (ce_l),
		.d_in      (req_tgl_reg),
		.level_out (),
		.edge_out  (req_edge)
	);

	// Finish toggle back to the reference domain
	i2ca_toggle_sync u_done_sync (
		.clk_in    (ref_clk_in),
		.rst_in    (srst_in),
		.ce_in     (ce_in),
		.d_in      (done_tgl_reg),
		.level_out (),
		.edge_out  (done_edge)
	);

	// Bus line sampling; filtered levels feed all decisions
	i2ca_line_filter u_filter (
		.clk_in  (link_clk_in),
		.rst_in  (rst_l),
		.ce_in   (ce_l),
		.scl_in  (scl_in),
		.sda_in  (sda_in),
		.lines   (lines.sampler)
	);

	// Command capture; held words stay still until the link answers
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			ready_reg   <= 1'b1;
			req_tgl_reg <= 1'b0;
			kind_reg    <= I2CA_CMD_START;
			data_reg    <= 8'h00;
			ack_reg     <= 1'b0;
		end else if (ce_in) begin
			if (cmd_valid_in && ready_reg) begin
				ready_reg   <= 1'b0;
				req_tgl_reg <= ~req_tgl_reg;
				kind_reg    <= i2ca_cmd_t'(cmd_kind_in);
				data_reg    <= cmd_data_in;
				ack_reg     <= cmd_ack_in;
			end else if (done_edge) begin
				ready_reg <= 1'b1;
			end
		end
	end

	// Answer registers, loaded when the finish toggle arrives
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			rsp_valid_reg <= 1'b0;
			rsp_data_reg  <= 8'h00;
			rsp_nack_reg  <= 1'b0;
			lost_out_reg  <= 1'b0;
		end else if (ce_in) begin
			rsp_valid_reg <= done_edge;
			lost_out_reg  <= done_edge & lost_reg;
			if (done_edge) begin
				// Link words are stable: link side idles until next command
				rsp_data_reg <= shift_reg;
				rsp_nack_reg <= nack_reg;
			end
		end
	end

	assign tx = tx_bit(kind_l_reg, bit_reg, shift_reg, ack_l_reg);

	// Bus engine: one bit cell is LOW, RISE, HIGH
	always_ff @(posedge link_clk_in) begin
		if (rst_l) begin
			state_reg    <= I2CA_ST_IDLE;
			cnt_reg      <= '0;
			bit_reg      <= 4'h0;
			shift_reg    <= 8'h00;
			smp_reg      <= 1'b1;
			kind_l_reg   <= I2CA_CMD_START;
			ack_l_reg    <= 1'b0;
			scl_oe_reg   <= 1'b0;
			sda_oe_reg   <= 1'b0;
			lost_reg     <= 1'b0;
			nack_reg     <= 1'b0;
			done_tgl_reg <= 1'b0;
		end else if (ce_l) begin
			case (state_reg)
				I2CA_ST_IDLE: begin
					if (req_edge) begin
						// Held words are stable since the toggle left
						kind_l_reg <= kind_reg;
						ack_l_reg  <= ack_reg;
						shift_reg  <= data_reg;
						bit_reg    <= 4'h0;
						cnt_reg    <= '0;
						lost_reg   <= 1'b0;
						nack_reg   <= 1'b0;
						if (kind_reg == I2CA_CMD_START) begin
							sda_oe_reg <= 1'b1;
							state_reg  <= I2CA_ST_START;
						end else begin
							scl_oe_reg <= 1'b1;
							state_reg  <= I2CA_ST_LOW;
						end
					end
				end
				I2CA_ST_START: begin
					// Data low first, then clock low after hold time
					cnt_reg <= cnt_reg + CNT_W'(1);
					if (!lines.scl || cnt_hit(cnt_reg, T_HD_CYC)) begin
						// A rival's earlier fall is followed at once
						scl_oe_reg <= 1'b1;
						state_reg  <= I2CA_ST_DONE;
					end
				end
				I2CA_ST_LOW: begin
					// Low time is counted from entry to LOW, when this end pulls the clock
					cnt_reg <= cnt_reg + CNT_W'(1);
					if (cnt_reg == `I2CA_SDA_HOLD) begin
						// Data changes two cycles after entry to LOW for hold time
						sda_oe_reg <= tx[1] & ~tx[0];
					end
					if (cnt_hit(cnt_reg, T_LOW_CYC)) begin
						scl_oe_reg <= 1'b0;
						cnt_reg    <= '0;
						state_reg  <= I2CA_ST_RISE;
					end
				end
				I2CA_ST_RISE: begin
					// Released but held low elsewhere: wait, with no timeout
					if (lines.scl) begin
						smp_reg   <= lines.sda;
						state_reg <= I2CA_ST_HIGH;
					end
				end
				I2CA_ST_HIGH: begin
					cnt_reg <= cnt_reg + CNT_W'(1);
					if (ARB_EN && tx[1] && tx[0] && kind_l_reg != I2CA_CMD_STOP &&
						lines.scl && !lines.sda) begin
						// Sent high, saw low: free both lines at once
						scl_oe_reg <= 1'b0;
						sda_oe_reg <= 1'b0;
						lost_reg   <= 1'b1;
						state_reg  <= I2CA_ST_DONE;
					end else if (kind_l_reg == I2CA_CMD_STOP) begin
						// Stop: release data while clock is high
						if (cnt_hit(cnt_reg, T_SU_CYC)) begin
							sda_oe_reg <= 1'b0;
							state_reg  <= I2CA_ST_DONE;
						end
					end else if (!lines.scl || cnt_hit(cnt_reg, T_HIGH_CYC)) begin
						// Earliest finisher ends the high phase for all
						scl_oe_reg <= 1'b1;
						cnt_reg    <= '0;
						if (bit_reg == `I2CA_ACK_IDX) begin
							// Byte complete; clock held low until next command
							nack_reg   <= smp_reg;
							sda_oe_reg <= 1'b0;
							state_reg  <= I2CA_ST_DONE;
						end else begin
							shift_reg <= {shift_reg[6:0], smp_reg};
							bit_reg   <= bit_reg + 4'h1;
							state_reg <= I2CA_ST_LOW;
						end
					end
				end
				I2CA_ST_DONE: begin
					done_tgl_reg <= ~done_tgl_reg;
					state_reg    <= I2CA_ST_IDLE;
				end
				default: begin
					state_reg <= I2CA_ST_IDLE;
				end
			endcase
		end
	end

	// Open-drain level is always low; only the enables move
	always_ff @(posedge link_clk_in) begin
		if (rst_l) begin
			zero_reg <= 1'b0;
		end else begin
			zero_reg <= 1'b0;
		end
	end

	assign cmd_ready_out = ready_reg;
	assign rsp_valid_out = rsp_valid_reg;
	assign rsp_data_out  = rsp_data_reg;
	assign rsp_nack_out  = rsp_nack_reg;
	assign arb_lost_out  = lost_out_reg;
	assign scl_out       = zero_reg;
	assign sda_out       = zero_reg;
	assign scl_oe_out    = scl_oe_reg;
	assign sda_oe_out    = sda_oe_reg;
endmodule

// >>> verif/i2ca_bus_model.sv
// Far-side bus model: a target that acks and stretches, plus a rival controller.
// Assumes the bench resolves both lines as wired-AND with pull-ups.
`timescale 1ns/100ps
module i2ca_bus_model (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	input  wire logic        ack_en_in,
	input  wire logic [10:0] stretch_in,
	input  wire logic        rival_en_in,
	input  wire logic [7:0]  rival_byte_in,
	output logic             scl_pull_out,
	output logic             sda_pull_out
);
	logic        scl_d;   // Last clock level
	logic        sda_d;   // Last data level
	logic        ack_bit; // Acknowledge pull
	logic        rv_bit;  // Rival data pull
	logic [3:0]  cnt;     // Falls since start, wrapping from 9 (acknowledge) back to 1; f = idle
	logic [7:0]  hcnt;    // Clock high run
	logic [10:0] hold;    // Clock pull countdown
	wire  [3:0]  nc = (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
	// Rival bit follows the live byte, so a new byte set between commands counts from bit one
	assign rv_bit = (cnt != 4'h0) && (cnt <= 4'h8) && !rival_byte_in[3'(4'h8 - cnt)];
	// Pull-only outputs, never driven high
	assign scl_pull_out = (hold != 11'h000);
	assign sda_pull_out = (ack_bit & ack_en_in) | (rv_bit & rival_en_in);
	// Bit tracking from seen falls, framed by start and stop
	always @(posedge clk_in) begin
		scl_d <= scl_in;
		sda_d <= sda_in;
		hcnt <= scl_in ? hcnt + 8'h01 : 8'h00;
		if (rst_in) begin
			cnt <= 4'hf;
			hcnt <= 8'h00;
			hold <= 11'h000;
			ack_bit <= 1'b0;
		end else if (scl_in && scl_d && sda_d != sda_in) begin
			cnt <= sda_in ? 4'hf : 4'h0;
		end else if (scl_d && !scl_in) begin
			cnt <= nc;
			ack_bit <= (nc == 4'h9);
			// Stretch the acknowledge bit, never cut a longer pull short
			if (nc == 4'h9 && stretch_in > hold)
				hold <= stretch_in;
		end else if (rival_en_in && hcnt == 8'h14 && cnt != 4'hf) begin
			hold <= 11'h050;
		end else if (hold != 11'h000) begin
			hold <= hold - 11'h001;
		end
	end
endmodule

// >>> verif/i2ca_top_sva.sv
// Port checker for the bus engine.
// Assumes bind onto i2ca_top; both clocks run free.
`timescale 1ns/100ps
module i2ca_top_sva (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic cmd_valid_in,
	input wire logic cmd_ready_out,
	input wire logic rsp_valid_out,
	input wire logic rsp_nack_out,
	input wire logic arb_lost_out,
	input wire logic link_clk_in,
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe_out,
	input wire logic sda_out,
	input wire logic sda_oe_out
);
	a_take_busy: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		cmd_valid_in && cmd_ready_out && ce_in |=> !cmd_ready_out) else $error("ready high after take");
	a_ready_rsp: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		rsp_valid_out |-> cmd_ready_out) else $error("answer without ready");
	a_lost_rsp: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		arb_lost_out |-> rsp_valid_out) else $error("loss without answer");
	a_loss_frees: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		arb_lost_out |-> !scl_oe_out && !sda_oe_out) else $error("lines held after loss");
	a_scl_od: assert property (@(posedge link_clk_in) disable iff (srst_in)
		scl_out == 1'b0) else $error("clock driven high");
	a_sda_od: assert property (@(posedge link_clk_in) disable iff (srst_in)
		sda_out == 1'b0) else $error("data driven high");
	// Data must not move while someone else holds the clock low
	a_stretch_quiet: assert property (@(posedge link_clk_in) disable iff (srst_in)
		!scl_oe_out && !scl_in && $past(scl_oe_out) == 1'b0 && $past(scl_in) == 1'b0
		|-> $stable(sda_oe_out)) else $error("data moved in stretch");
	// A foreign fall ends our high phase within filter latency
	a_follow_fall: assert property (@(posedge link_clk_in) disable iff (srst_in)
		!scl_oe_out && $past(scl_in) && !scl_in && !cmd_ready_out
		|-> ##[1:8] scl_oe_out) else $error("foreign fall not followed");
	c_loss: cover property (@(posedge ref_clk_in) arb_lost_out);
	c_nack: cover property (@(posedge ref_clk_in) rsp_valid_out && rsp_nack_out);
	c_stretch: cover property (@(posedge link_clk_in) !scl_oe_out && !scl_in);
endmodule
bind i2ca_top i2ca_top_sva u_sva (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .ce_in(ce_in),
	.cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out),
	.rsp_nack_out(rsp_nack_out), .arb_lost_out(arb_lost_out), .link_clk_in(link_clk_in), .scl_in(scl_in),
	.scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_out(sda_out), .sda_oe_out(sda_oe_out));

// >>> verif/i2ca_top_tb_top.sv
// Bench for the bus engine: stretch, ack, read, stop, arbitration.
// Assumes the bus model stands for targets and one rival controller.
`timescale 1ns/100ps
module i2ca_top_tb_top import i2ca_pkg::*; ;
	logic        ref_clk = 1'b0; // User clock
	logic        link_clk = 1'b1; // Link clock
	logic        srst = 1'b1;    // Sync reset
	logic        ce = 1'b1;      // Clock enable
	logic        cmd_valid, cmd_ack, ack_en, rival_en, ready, rsp_v, rsp_nack, lost;
	logic        scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda;
	logic [1:0]  cmd_kind;
	logic [7:0]  cmd_data, rival_byte, rsp_data;
	logic [10:0] stretch;        // Target stretch, link cycles
	int          miscompares = 0, n_compared = 0, lat, cyc = 0;
	// Pull-ups: a line is low if anyone pulls
	wire         scl = !(scl_oe | m_scl);
	wire         sda = !(sda_oe | m_sda);
	always #12.5 ref_clk = ~ref_clk;
	// Offset start keeps link edges off the user clock edges
	initial begin
		#7;
		forever #40 link_clk = ~link_clk;
	end
	i2ca_top uut (.ref_clk_in(ref_clk), .srst_in(srst), .ce_in(ce), .cmd_valid_in(cmd_valid),
		.cmd_kind_in(cmd_kind), .cmd_data_in(cmd_data), .cmd_ack_in(cmd_ack), .cmd_ready_out(ready),
		.rsp_valid_out(rsp_v), .rsp_data_out(rsp_data), .rsp_nack_out(rsp_nack), .arb_lost_out(lost),
		.link_clk_in(link_clk), .scl_in(scl), .sda_in(sda), .scl_out(scl_o), .scl_oe_out(scl_oe),
		.sda_out(sda_o), .sda_oe_out(sda_oe));
	i2ca_bus_model u_bus (.clk_in(link_clk), .rst_in(srst), .scl_in(scl), .sda_in(sda), .ack_en_in(ack_en),
		.stretch_in(stretch), .rival_en_in(rival_en), .rival_byte_in(rival_byte), .scl_pull_out(m_scl),
		.sda_pull_out(m_sda));
	task automatic results;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One command, then wait for its answer; lat counts user cycles
	task automatic cmd(input i2ca_cmd_t k, input logic [7:0] d, input logic a);
		while (ready !== 1'b1)
			@(negedge ref_clk);
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd_kind <= k;
		cmd_data <= d;
		cmd_ack <= a;
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		lat = 0;
		do begin
			@(negedge ref_clk);
			lat++;
		end while (rsp_v !== 1'b1);
	endtask
	task automatic t_stretch;
		int base;
		ack_en = 1'b1;
		cmd(I2CA_CMD_START, 8'h00, 1'b0);
		check(lost, 1'b0);
		cmd(I2CA_CMD_WRITE, 8'ha5, 1'b0);
		base = lat;
		check(rsp_nack, 1'b0);
		stretch = 11'd1200;
		cmd(I2CA_CMD_WRITE, 8'h5a, 1'b0);
		check(lat > base + 3500, 1'b1);
		check(rsp_nack, 1'b0);
		stretch = 11'd0;
	endtask
	task automatic t_nack;
		ack_en = 1'b0;
		cmd(I2CA_CMD_WRITE, 8'h3c, 1'b0);
		check(rsp_nack, 1'b1);
	endtask
	task automatic t_read;
		cmd(I2CA_CMD_READ, 8'h00, 1'b1);
		check(rsp_data, 8'hff);
	endtask
	// Enable dropped mid-byte: answer late by the frozen time, still complete
	task automatic t_freeze;
		int base;
		cmd(I2CA_CMD_WRITE, 8'h96, 1'b0);
		base = lat;
		fork
			cmd(I2CA_CMD_WRITE, 8'h69, 1'b0);
			begin
				repeat (200) @(posedge ref_clk);
				ce <= 1'b0;
				repeat (2000) @(posedge ref_clk);
				ce <= 1'b1;
			end
		join
		check(lat > base + 1900, 1'b1);
		check(rsp_nack, 1'b1);
	endtask
	task automatic t_stop;
		cmd(I2CA_CMD_STOP, 8'h00, 1'b0);
		repeat (10) @(negedge ref_clk);
		check({scl_oe, sda_oe}, 2'b00);
		check({scl, sda}, 2'b11);
	endtask
	// Rival sends 01 then fe; we send 00 (win) then ff (lose)
	task automatic t_arb;
		ack_en = 1'b1;
		rival_en = 1'b1;
		rival_byte = 8'h01;
		cmd(I2CA_CMD_START, 8'h00, 1'b0);
		cmd(I2CA_CMD_WRITE, 8'h00, 1'b0);
		check(lost, 1'b0);
		rival_byte = 8'hfe;
		cmd(I2CA_CMD_WRITE, 8'hff, 1'b0);
		check(lost, 1'b1);
		check({scl_oe, sda_oe}, 2'b00);
		rival_en = 1'b0;
		ack_en = 1'b0;
		repeat (400) @(negedge ref_clk);
		cmd(I2CA_CMD_START, 8'h00, 1'b0);
		check(lost, 1'b0);
		cmd(I2CA_CMD_STOP, 8'h00, 1'b0);
	endtask
	// Hang guard, about twice the expected run
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			miscompares++;
			results();
		end
	end
	initial begin
		cmd_valid = 1'b0;
		cmd_kind = 2'b00;
		cmd_data = 8'h00;
		cmd_ack = 1'b0;
		ack_en = 1'b0;
		rival_en = 1'b0;
		rival_byte = 8'h00;
		stretch = 11'd0;
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (20) @(posedge ref_clk);
		t_stretch();
		t_nack();
		t_read();
		t_freeze();
		t_stop();
		t_arb();
		results();
	end
endmodule
